// [design/hpcm_monitor.sv]
`timescale 1ns/1ps
module hpcm_monitor #(
  parameter int NPORTS = hpcm_pkg::NUM_PORTS,
  parameter int RESET_CYC = hpcm_pkg::RESET_CYCLES,
  parameter int RESUME_CYC = hpcm_pkg::RESUME_CYCLES
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Register port
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  // Frame timing from the serial engine
  input wire logic eof_pulse,
  // Port events, one bit per port, port 1 at bit 0; hub_change is a single hub bit
  input wire logic [NPORTS-1:0] hw_connect_chg,
  input wire logic [NPORTS-1:0] hw_enable_chg,
  input wire logic [NPORTS-1:0] fw_enable_done,
  input wire logic hub_change,
  // Downstream drive
  output logic [NPORTS-1:0] drive_reset,
  output logic [NPORTS-1:0] drive_resume,
  // Endpoint 1 transmit byte
  input wire logic ep1_tx_taken,
  output logic [7:0] endpoint_transmit_byte,
  // Interrupt
  output logic irq
);
  logic [2:0] hub_port_select_index;
  logic [2:0] next_index;
  logic [2:0] irq_stat;
  logic [2:0] next_irq_stat;
  logic [2:0] irq_mask;
  logic [2:0] next_irq_mask;
  logic [7:0] next_tx;
  logic [7:0] next_rdata;
  logic [NPORTS-1:0] sel;
  logic [NPORTS-1:0] rst_start;
  logic [NPORTS-1:0] res_start;
  logic [NPORTS-1:0] rst_done;
  logic [NPORTS-1:0] res_done;
  logic [NPORTS-1:0] raised;
  logic [3:0] hw_set [NPORTS];
  logic [3:0] fw_set [NPORTS];
  logic [3:0] clr [NPORTS];
  logic [3:0] flags [NPORTS];
  logic [3:0] pending [NPORTS];
  logic [3:0] wr_clr;

  // Change register write maps reserved bits away
  assign wr_clr = {wdata[hpcm_pkg::BIT_RESET], wdata[hpcm_pkg::BIT_SUSPEND],
                   wdata[hpcm_pkg::BIT_ENABLE], wdata[hpcm_pkg::BIT_CONNECT]};

  // Per-port timers and flag banks
  genvar i;
  generate
    for (i = 0; i < NPORTS; i++) begin : g_port
      assign sel[i] = (hub_port_select_index == 3'(i + 1));
      assign rst_start[i] = wr && (addr == hpcm_pkg::ADDR_CMD) && sel[i]
                            && wdata[hpcm_pkg::CMD_RESET];
      assign res_start[i] = wr && (addr == hpcm_pkg::ADDR_CMD) && sel[i]
                            && wdata[hpcm_pkg::CMD_RESUME];
      assign clr[i] = (wr && (addr == hpcm_pkg::ADDR_CHANGE) && sel[i])
                      ? wr_clr : 4'h0;

      hpcm_drive_timer #(.CYCLES(RESET_CYC)) u_reset (
        .clk(clk),
        .rst(rst),
        .start(rst_start[i]),
        .busy(drive_reset[i]),
        .done(rst_done[i])
      );

      hpcm_drive_timer #(.CYCLES(RESUME_CYC)) u_resume (
        .clk(clk),
        .rst(rst),
        .start(res_start[i]),
        .busy(drive_resume[i]),
        .done(res_done[i])
      );

      always_comb begin
        hw_set[i] = 4'h0;
        hw_set[i][hpcm_pkg::F_CON] = hw_connect_chg[i];
        hw_set[i][hpcm_pkg::F_EN] = hw_enable_chg[i];
        if (i != 0) begin
          hw_set[i][hpcm_pkg::F_RST] = rst_done[i];
        end
      end

      always_comb begin
        fw_set[i] = 4'h0;
        fw_set[i][hpcm_pkg::F_SUS] = res_done[i];
        fw_set[i][hpcm_pkg::F_EN] = fw_enable_done[i];
        // Internal port reset is held to end of frame
        if (i == 0) begin
          fw_set[i][hpcm_pkg::F_RST] = rst_done[i];
        end
      end

      // firmware sets wait for end of frame
      hpcm_change_flags u_flags (
        .clk(clk),
        .rst(rst),
        .eof(eof_pulse),
        .hw_set(hw_set[i]),
        .fw_set(fw_set[i]),
        .clr(clr[i]),
        .flags(flags[i]),
        .pending(pending[i]),
        .raised(raised[i])
      );
    end
  endgenerate

  // Register writes and sticky state
  always_comb begin
    next_index = hub_port_select_index;
    next_irq_mask = irq_mask;
    next_irq_stat = irq_stat;
    next_tx = endpoint_transmit_byte;
    if (wr && addr == hpcm_pkg::ADDR_INDEX) begin
      next_index = wdata[2:0];
    end
    if (wr && addr == hpcm_pkg::ADDR_IRQ_MASK) begin
      next_irq_mask = wdata[2:0];
    end
    if (wr && addr == hpcm_pkg::ADDR_IRQ_STAT) begin
      next_irq_stat = irq_stat & ~wdata[2:0];
    end
    // Host pickup clears; a new change in that cycle survives
    if (ep1_tx_taken) begin
      next_tx = 8'h00;
    end
    for (int p = 0; p < NPORTS; p++) begin
      if (raised[p]) begin
        next_tx[p + 1] = 1'b1;
      end
    end
    if (hub_change) begin
      next_tx[0] = 1'b1;
    end
    // Events win over a write-one clear
    if (|raised) begin
      next_irq_stat[hpcm_pkg::IRQ_CHANGE] = 1'b1;
    end
    if (|rst_done) begin
      next_irq_stat[hpcm_pkg::IRQ_RESET_DONE] = 1'b1;
    end
    if (|res_done) begin
      next_irq_stat[hpcm_pkg::IRQ_RESUME_DONE] = 1'b1;
    end
  end

  // flags polled by reads
  // Read data, one cycle after the strobe
  always_comb begin
    next_rdata = 8'h00;
    if (rd) begin
      unique case (addr)
        hpcm_pkg::ADDR_INDEX: next_rdata = {5'h00, hub_port_select_index};
        hpcm_pkg::ADDR_TXBYTE: next_rdata = endpoint_transmit_byte;
        hpcm_pkg::ADDR_IRQ_STAT: next_rdata = {5'h00, irq_stat};
        hpcm_pkg::ADDR_IRQ_MASK: next_rdata = {5'h00, irq_mask};
        hpcm_pkg::ADDR_CHANGE: begin
          for (int p = 0; p < NPORTS; p++) begin
            if (sel[p]) begin
              next_rdata[hpcm_pkg::BIT_RESET] = flags[p][hpcm_pkg::F_RST];
              next_rdata[hpcm_pkg::BIT_SUSPEND] = flags[p][hpcm_pkg::F_SUS];
              next_rdata[hpcm_pkg::BIT_ENABLE] = flags[p][hpcm_pkg::F_EN];
              next_rdata[hpcm_pkg::BIT_CONNECT] = flags[p][hpcm_pkg::F_CON];
            end
          end
        end
        default: next_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hub_port_select_index <= hpcm_pkg::RST_INDEX;
      irq_stat <= hpcm_pkg::RST_IRQ;
      irq_mask <= hpcm_pkg::RST_IRQ;
      endpoint_transmit_byte <= hpcm_pkg::RST_CHANGE;
      rdata <= 8'h00;
    end else begin
      hub_port_select_index <= next_index;
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
      endpoint_transmit_byte <= next_tx;
      rdata <= next_rdata;
    end
  end

  // Level interrupt from unmasked sticky bits
  assign irq = |(irq_stat & irq_mask);

  // Checks
  property p_port1_eof;
    @(posedge clk) disable iff (rst)
    $rose(flags[0][hpcm_pkg::F_RST]) |-> $past(eof_pulse);
  endproperty
  a_port1_eof: assert property (p_port1_eof)
    else $error("internal port reset flag set outside end of frame");

  property p_ds_reset;
    @(posedge clk) disable iff (rst)
    rst_done[1] |=> flags[1][hpcm_pkg::F_RST];
  endproperty
  a_ds_reset: assert property (p_ds_reset)
    else $error("downstream reset flag not set after drive");

  property p_resume_hold;
    @(posedge clk) disable iff (rst)
    (res_start[0] && !drive_resume[0]) |=> drive_resume[0] [*8];
  endproperty
  a_resume_hold: assert property (p_resume_hold)
    else $error("resume drive ended early");

  property p_resume_wait;
    @(posedge clk) disable iff (rst)
    (res_done[0] && !eof_pulse) ##1 !eof_pulse
      |-> pending[0][hpcm_pkg::F_SUS];
  endproperty
  a_resume_wait: assert property (p_resume_wait)
    else $error("resume completion not held pending");

  property p_hw_connect;
    @(posedge clk) disable iff (rst)
    hw_connect_chg[0] |=> flags[0][hpcm_pkg::F_CON];
  endproperty
  a_hw_connect: assert property (p_hw_connect)
    else $error("hardware connect change not recorded");

  property p_tx_bit;
    @(posedge clk) disable iff (rst)
    raised[0] |=> endpoint_transmit_byte[1];
  endproperty
  a_tx_bit: assert property (p_tx_bit)
    else $error("transmit byte misses port change");

  property p_read_sel;
    @(posedge clk) disable iff (rst)
    (rd && addr == hpcm_pkg::ADDR_CHANGE && sel[0])
      |=> rdata[hpcm_pkg::BIT_RESET] == $past(flags[0][hpcm_pkg::F_RST])
      && rdata[hpcm_pkg::BIT_CONNECT] == $past(flags[0][hpcm_pkg::F_CON]);
  endproperty
  a_read_sel: assert property (p_read_sel)
    else $error("change read does not show selected port");

  property p_reserved;
    @(posedge clk) disable iff (rst)
    $past(rd && addr == hpcm_pkg::ADDR_CHANGE)
      |-> rdata[7:5] == 3'h0 && rdata[3] == 1'b0;
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved change bits read nonzero");

  property p_irq_clear;
    @(posedge clk) disable iff (rst)
    (wr && addr == hpcm_pkg::ADDR_IRQ_STAT && wdata[0] && !(|raised))
      |=> !irq_stat[hpcm_pkg::IRQ_CHANGE];
  endproperty
  a_irq_clear: assert property (p_irq_clear)
    else $error("change interrupt not cleared by write");
endmodule

// [design/hpcm_pkg.sv]
package hpcm_pkg;
  // Register byte addresses
  localparam logic [7:0] ADDR_INDEX = 8'hd0;
  localparam logic [7:0] ADDR_TXBYTE = 8'hd1;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'hd2;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'hd3;
  localparam logic [7:0] ADDR_CMD = 8'hd4;
  localparam logic [7:0] ADDR_CHANGE = 8'hd5;
  // Change register bit positions
  localparam int BIT_CONNECT = 0;
  localparam int BIT_ENABLE = 1;
  localparam int BIT_SUSPEND = 2;
  localparam int BIT_RESET = 4;
  // Internal flag vector order {reset, suspend, enable, connect}
  localparam int F_CON = 0;
  localparam int F_EN = 1;
  localparam int F_SUS = 2;
  localparam int F_RST = 3;
  // Command register bits
  localparam int CMD_RESET = 0;
  localparam int CMD_RESUME = 1;
  // Interrupt status bits
  localparam int IRQ_CHANGE = 0;
  localparam int IRQ_RESET_DONE = 1;
  localparam int IRQ_RESUME_DONE = 2;
  // Reset values
  localparam logic [7:0] RST_CHANGE = 8'h00;
  localparam logic [2:0] RST_INDEX = 3'h0;
  localparam logic [2:0] RST_IRQ = 3'h0;
  // Timing
  localparam int CLK_HZ = 10_000_000;
  localparam int RESET_TIME_MS = 10;
  localparam int RESUME_TIME_MS = 20;
  localparam int RESET_CYCLES = RESET_TIME_MS * (CLK_HZ / 1000);
  localparam int RESUME_CYCLES = RESUME_TIME_MS * (CLK_HZ / 1000);
  localparam int NUM_PORTS = 5;
endpackage

// [design/hpcm_drive_timer.sv]
`timescale 1ns/1ps
// Drives a downstream bus state for a fixed number of cycles
module hpcm_drive_timer #(
  parameter int CYCLES = 100000
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Control
  input wire logic start,
  output logic busy,
  output logic done
);
  localparam int W = $clog2(CYCLES + 1);
  localparam logic [W-1:0] LAST = W'(CYCLES - 1);
  logic [W-1:0] count;
  logic [W-1:0] next_count;
  logic next_busy;

  // Restart is ignored while a drive is running
  always_comb begin
    next_count = count;
    next_busy = busy;
    if (busy) begin
      next_count = count + W'(1);
      if (count == LAST) begin
        next_busy = 1'b0;
        next_count = '0;
      end
    end else if (start) begin
      next_busy = 1'b1;
      next_count = '0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      count <= '0;
      busy <= 1'b0;
    end else begin
      count <= next_count;
      busy <= next_busy;
    end
  end

  assign done = busy && (count == LAST);
endmodule

// [design/hpcm_change_flags.sv]
`timescale 1ns/1ps
// Change flags of one port, with firmware changes held to end of frame
module hpcm_change_flags (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Events
  input wire logic eof,
  input wire logic [3:0] hw_set,
  input wire logic [3:0] fw_set,
  input wire logic [3:0] clr,
  // State
  output logic [3:0] flags,
  output logic [3:0] pending,
  output logic raised
);
  logic [3:0] next_flags;
  logic [3:0] next_pending;

  // Sets win over a clear in the same cycle
  always_comb begin
    next_pending = pending | fw_set;
    next_flags = (flags & ~clr) | hw_set;
    if (eof) begin
      next_flags = next_flags | pending;
      next_pending = fw_set;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flags <= 4'h0;
      pending <= 4'h0;
    end else begin
      flags <= next_flags;
      pending <= next_pending;
    end
  end

  assign raised = |(next_flags & ~flags);
endmodule

// [sim/hpcm_host_model.sv]
`timescale 1ns/1ps
// Host side: polls endpoint 1 after a stall, then takes the byte
module hpcm_host_model #(
  parameter int STALL = 4
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Poll control
  input wire logic en,
  // Endpoint 1
  input wire logic [7:0] tx_byte,
  output logic taken,
  output logic [7:0] got
);
  int wait_cnt;
  // poll then read
  // Stall first so the byte is seen to stand until taken
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wait_cnt <= 0;
      taken <= 1'b0;
      got <= 8'h00;
    end else begin
      taken <= 1'b0;
      if (en && tx_byte != 8'h00 && !taken) begin
        wait_cnt <= wait_cnt + 1;
        if (wait_cnt == STALL) begin
          taken <= 1'b1;
          got <= tx_byte;
          wait_cnt <= 0;
        end
      end
    end
  end
endmodule

// [sim/hub_port_change_monitor_test.sv]
`timescale 1ns/1ps
module hub_port_change_monitor_test;
  localparam int RST_C = 20;
  localparam int RES_C = 40;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] rdata;
  logic eof_pulse = 1'b0;
  logic [4:0] hw_con = 5'h00;
  logic [4:0] hw_en = 5'h00;
  logic [4:0] fw_en = 5'h00;
  logic hub_change = 1'b0;
  logic [4:0] drive_reset;
  logic [4:0] drive_resume;
  logic host_en = 1'b0;
  logic ep1_tx_taken;
  logic [7:0] tx_byte;
  logic [7:0] host_got;
  logic irq;
  int fail_count = 0;
  int checks = 0;
  int n;
  // Free-running clock
  always #50 clk = ~clk;
  hpcm_monitor #(.NPORTS(5), .RESET_CYC(RST_C), .RESUME_CYC(RES_C)) u_dut (
    .clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .eof_pulse(eof_pulse), .hw_connect_chg(hw_con),
    .hw_enable_chg(hw_en), .fw_enable_done(fw_en), .hub_change(hub_change),
    .drive_reset(drive_reset), .drive_resume(drive_resume),
    .ep1_tx_taken(ep1_tx_taken), .endpoint_transmit_byte(tx_byte), .irq(irq));
  hpcm_host_model #(.STALL(4)) u_host (.clk(clk), .rst(rst), .en(host_en),
    .tx_byte(tx_byte), .taken(ep1_tx_taken), .got(host_got));
  // Verdict, reached from the end of the tests or the watchdog
  task automatic wrap_up();
    $display("Counts: %0d checks, %0d mismatches", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk8(rdata, exp);
  endtask
  task automatic port_chk(input logic [2:0] p, input logic [7:0] exp);
    reg_wr(hpcm_pkg::ADDR_INDEX, {5'h00, p});
    rd_chk(hpcm_pkg::ADDR_CHANGE, exp);
  endtask
  task automatic irq_chk(input logic exp);
    @(posedge clk);
    #1;
    chk8({7'h00, irq}, {7'h00, exp});
  endtask
  task automatic eof();
    @(posedge clk);
    eof_pulse <= 1'b1;
    @(posedge clk);
    eof_pulse <= 1'b0;
    repeat (2) @(posedge clk);
  endtask
  // Length of a drive on port 2, bounded wait for its start
  task automatic count_drive(input logic res, output int k);
    int w;
    k = 0;
    w = 0;
    #1;
    while ((res ? drive_resume[1] : drive_reset[1]) !== 1'b1 && w < 10) begin
      @(posedge clk);
      #1;
      w++;
    end
    while ((res ? drive_resume[1] : drive_reset[1]) === 1'b1 && k < 500) begin
      @(posedge clk);
      #1;
      k++;
    end
  endtask
  task automatic t_reset_values();
    port_chk(3'h1, 8'h00);
    rd_chk(8'h40, 8'h00);
    chk8(tx_byte, 8'h00);
    chk8({7'h00, irq}, 8'h00);
    $display("reset values done");
  endtask
  task automatic t_hw_change();
    @(posedge clk);
    hw_con <= 5'h02;
    hw_en <= 5'h02;
    @(posedge clk);
    hw_con <= 5'h00;
    hw_en <= 5'h00;
    port_chk(3'h3, 8'h00);
    port_chk(3'h2, 8'h03);
    chk8(tx_byte, 8'h04);
    // Write one clears connect and enable of port 2
    reg_wr(hpcm_pkg::ADDR_CHANGE, 8'h03);
    rd_chk(hpcm_pkg::ADDR_CHANGE, 8'h00);
    $display("hardware change done");
  endtask
  task automatic t_fw_enable();
    @(posedge clk);
    fw_en <= 5'h04;
    @(posedge clk);
    fw_en <= 5'h00;
    port_chk(3'h3, 8'h00);
    eof();
    rd_chk(hpcm_pkg::ADDR_CHANGE, 8'h02);
    chk8(tx_byte, 8'h0c);
    reg_wr(hpcm_pkg::ADDR_CHANGE, 8'h02);
    $display("firmware enable done");
  endtask
  task automatic t_port_reset();
    reg_wr(hpcm_pkg::ADDR_INDEX, 8'h02);
    reg_wr(hpcm_pkg::ADDR_CMD, 8'h01);
    count_drive(1'b0, n);
    chk8(8'(n), 8'(RST_C));
    repeat (2) @(posedge clk);
    rd_chk(hpcm_pkg::ADDR_CHANGE, 8'h10);
    reg_wr(hpcm_pkg::ADDR_CHANGE, 8'h10);
    $display("port reset done");
  endtask
  task automatic t_irq();
    irq_chk(1'b0);
    rd_chk(hpcm_pkg::ADDR_IRQ_STAT, 8'h03);
    reg_wr(hpcm_pkg::ADDR_IRQ_MASK, 8'h02);
    rd_chk(hpcm_pkg::ADDR_IRQ_MASK, 8'h02);
    irq_chk(1'b1);
    reg_wr(hpcm_pkg::ADDR_IRQ_STAT, 8'h02);
    irq_chk(1'b0);
    rd_chk(hpcm_pkg::ADDR_IRQ_STAT, 8'h01);
    reg_wr(hpcm_pkg::ADDR_IRQ_STAT, 8'h07);
    $display("interrupt done");
  endtask
  task automatic t_resume();
    reg_wr(hpcm_pkg::ADDR_CMD, 8'h02);
    count_drive(1'b1, n);
    chk8(8'(n), 8'(RES_C));
    repeat (3) @(posedge clk);
    rd_chk(hpcm_pkg::ADDR_CHANGE, 8'h00);
    eof();
    rd_chk(hpcm_pkg::ADDR_CHANGE, 8'h04);
    rd_chk(hpcm_pkg::ADDR_IRQ_STAT, 8'h05);
    $display("resume done");
  endtask
  task automatic t_host_poll();
    @(posedge clk);
    hub_change <= 1'b1;
    @(posedge clk);
    hub_change <= 1'b0;
    @(posedge clk);
    #1;
    chk8(tx_byte, 8'h0f);
    host_en <= 1'b1;
    repeat (20) @(posedge clk);
    chk8(host_got, 8'h0f);
    chk8(tx_byte, 8'h00);
    // Change word of the reported port, flags stand until cleared
    port_chk(3'h2, 8'h04);
    $display("host poll done");
  endtask
  // Internal port: reset and resume completions wait for end of frame
  task automatic t_port1();
    reg_wr(hpcm_pkg::ADDR_INDEX, 8'h01);
    rd_chk(hpcm_pkg::ADDR_INDEX, 8'h01);
    @(posedge clk);
    hw_con <= 5'h01;
    @(posedge clk);
    hw_con <= 5'h00;
    reg_wr(hpcm_pkg::ADDR_CMD, 8'h03);
    repeat (RES_C + 5) @(posedge clk);
    rd_chk(hpcm_pkg::ADDR_CHANGE, 8'h01);
    eof();
    rd_chk(hpcm_pkg::ADDR_CHANGE, 8'h15);
    rd_chk(hpcm_pkg::ADDR_TXBYTE, 8'h0e);
    reg_wr(hpcm_pkg::ADDR_CHANGE, 8'h15);
    rd_chk(hpcm_pkg::ADDR_CHANGE, 8'h00);
    $display("internal port done");
  endtask
  // Reset in mid-run drops every flag and register
  task automatic t_mid_reset();
    @(posedge clk);
    hw_con <= 5'h02;
    @(posedge clk);
    hw_con <= 5'h00;
    port_chk(3'h2, 8'h05);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    port_chk(3'h2, 8'h00);
    rd_chk(hpcm_pkg::ADDR_IRQ_STAT, 8'h00);
    rd_chk(hpcm_pkg::ADDR_IRQ_MASK, 8'h00);
    chk8(tx_byte, 8'h00);
    chk8({7'h00, irq}, 8'h00);
    $display("mid-run reset done");
  endtask
  // Watchdog: tests take well under a thousand cycles
  initial begin
    #(3000 * 100);
    fail_count++;
    wrap_up();
  end
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_reset_values();
    t_hw_change();
    t_fw_enable();
    t_port_reset();
    t_irq();
    t_resume();
    t_port1();
    t_host_poll();
    t_mid_reset();
    wrap_up();
  end
endmodule
